// >>> src/qmrp_defs.svh
`ifndef QMRP_DEFS_SVH
`define QMRP_DEFS_SVH

// ==============================================================
// serial opcodes
`define QMRP_OP_WREN 8'h06
`define QMRP_OP_WRDI 8'h04
`define QMRP_OP_QEN 8'h38
`define QMRP_OP_QDIS 8'hFF
`define QMRP_OP_SETRP 8'hC0
`define QMRP_OP_SBW 8'h77
`define QMRP_OP_FREAD 8'h0B
`define QMRP_OP_QIOR 8'hEB
`define QMRP_OP_WRAPRD 8'h0C
`define QMRP_OP_RSTEN 8'h66
`define QMRP_OP_RST 8'h99
`define QMRP_OP_SFDP 8'h5A

// ==============================================================
// dummy clocks and wrap
`define QMRP_DUM_4 4'h4
`define QMRP_DUM_6 4'h6
`define QMRP_DUM_8 4'h8
`define QMRP_DUM_STD 4'h8
`define QMRP_DUM_SFDP 4'h8
`define QMRP_WRAP_BASE 24'h000008
`define QMRP_ADDR_BYTES 2'h2
`define QMRP_SBW_BYTES 2'h3
`define QMRP_STEP_STD 3'h1
`define QMRP_STEP_QUAD 3'h4

// ==============================================================
// pins
`define QMRP_PIN_INIT 6'h20
`define QMRP_OEN_OFF 4'hF
`define QMRP_OEN_SO 4'hD
`define QMRP_OEN_ALL 4'h0

// ==============================================================
// timing
`define QMRP_CLK_NS 4
`define QMRP_TRST_NS 30000

// ==============================================================
// apb map and fields
`define QMRP_REG_CTRL 12'h000
`define QMRP_REG_STAT 12'h004
`define QMRP_CTRL_QE 0
`define QMRP_CTRL_SUS 1
`define QMRP_ST_QUAD 0
`define QMRP_ST_WEL 1
`define QMRP_ST_SUS 2
`define QMRP_ST_BUSY 3
`define QMRP_ST_ARM 4
`define QMRP_ST_RP 8
`define QMRP_ST_WRAP 16
`define QMRP_ST_WLEN 20
`define QMRP_ST_MODE 24

`endif

// >>> src/qmrp_pkg.sv
package qmrp_pkg;
	// ==============================================================
	// engine states
	typedef enum {
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_MODE,
		ST_DUMMY,
		ST_DIN,
		ST_DOUT,
		ST_HOLD,
		ST_SKIP
	} qmrp_state_e;

	// ==============================================================
	// pin bundles
	typedef struct packed {
		logic csN;
		logic sclk;
		logic [3:0] io;
	} qmrp_pins_s;

	typedef struct packed {
		logic [3:0] ioOut;
		logic [3:0] ioOeN;
	} qmrp_drive_s;
endpackage : qmrp_pkg

// >>> src/qmrp_pin_sync.sv
module qmrp_pin_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	// ==============================================================
	// three stages; a level counts once stages two and three agree
	logic [W-1:0] s1_r, s2_r, s3_r, stable_r;
	logic [W-1:0] stable_nxt;

	// only s2/s3 are looked at, s1 feeds s2 alone
	always_comb begin
		for (int i = 0; i < W; i++) begin
			stable_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stable_r[i];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			stable_r <= INIT;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			stable_r <= stable_nxt;
		end
	end

	assign pinOut = stable_r;
endmodule : qmrp_pin_sync

// >>> src/qmrp_sfdp_rom.sv
`include "qmrp_defs.svh"

module qmrp_sfdp_rom #(
	parameter logic [7:0] MAKER_ID = 8'h3D // arbitrary value
) (
	input wire logic [23:0] addr,
	output logic [7:0] data
);
	// ==============================================================
	// header bytes; tables beyond the headers read as erased
	always_comb begin
		case (addr)
			24'h000000: data = 8'h53;
			24'h000001: data = 8'h46;
			24'h000002: data = 8'h44;
			24'h000003: data = 8'h50;
			24'h000004: data = 8'h00;
			24'h000005: data = 8'h01;
			24'h000006: data = 8'h01;
			24'h000008: data = 8'h00;
			24'h000009: data = 8'h00;
			24'h00000A: data = 8'h01;
			24'h00000B: data = 8'h09;
			24'h00000C: data = 8'h30;
			24'h00000D: data = 8'h00;
			24'h00000E: data = 8'h00;
			24'h000010: data = MAKER_ID;
			24'h000011: data = 8'h00;
			24'h000012: data = 8'h01;
			24'h000013: data = 8'h03;
			24'h000014: data = 8'h60;
			24'h000015: data = 8'h00;
			24'h000016: data = 8'h00;
			default: data = 8'hFF;
		endcase
	end
endmodule : qmrp_sfdp_rom

// >>> src/qmrp_cmd_engine.sv
`include "qmrp_defs.svh"

module qmrp_cmd_engine
	import qmrp_pkg::*;
#(
	parameter int RST_NS = `QMRP_TRST_NS,
	parameter int AW = 12,
	parameter logic [7:0] MAKER_ID = 8'h3D // arbitrary value
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire qmrp_pins_s pinIn,
	output qmrp_drive_s pinDrive,
	output logic [23:0] memAddr,
	input wire logic [7:0] memData,
	output logic quadMode
);
	// ==============================================================
	// timing
	localparam int RST_CYC = (RST_NS + `QMRP_CLK_NS - 1) / `QMRP_CLK_NS;
	localparam int BW = $clog2(RST_CYC + 1);
	localparam logic [BW-1:0] RST_LOAD = BW'(RST_CYC);

	// ==============================================================
	// pin sampling
	logic [5:0] pinSync;
	logic csN, sclk;
	logic [3:0] ioIn;
	logic [7:0] romData;

	qmrp_pin_sync #(.W(6), .INIT(`QMRP_PIN_INIT)) u_sync (
		.clock(clock),
		.resetn(resetn),
		.pinIn({pinIn.csN, pinIn.sclk, pinIn.io}),
		.pinOut(pinSync)
	);

	assign csN = pinSync[5];
	assign sclk = pinSync[4];
	assign ioIn = pinSync[3:0];

	// ==============================================================
	// state
	qmrp_state_e state_r, state_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic [7:0] opc_r, opc_nxt, sh_r, sh_nxt, outSh_r, outSh_nxt;
	logic [7:0] rp_r, rp_nxt, modeBits_r, modeBits_nxt;
	logic [2:0] bitCnt_r, bitCnt_nxt, outCnt_r, outCnt_nxt;
	logic [2:0] wrapBits_r, wrapBits_nxt;
	logic [1:0] byteCnt_r, byteCnt_nxt, wrapLen_r, wrapLen_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic quad_r, quad_nxt, wel_r, wel_nxt, sus_r, sus_nxt, qe_r, qe_nxt;
	logic arm_r, arm_nxt, sclkD_r, csD_r;
	logic [BW-1:0] busy_r, busy_nxt;
	logic [31:0] prdata_r, prdata_nxt, statWord;

	qmrp_sfdp_rom #(.MAKER_ID(MAKER_ID)) u_rom (
		.addr(addr_r),
		.data(romData)
	);

	// ==============================================================
	// helpers
	function automatic qmrp_state_e decodeOp(input logic [7:0] op, input logic q);
		case (op)
			`QMRP_OP_WREN, `QMRP_OP_WRDI: decodeOp = ST_HOLD;
			`QMRP_OP_RSTEN, `QMRP_OP_RST: decodeOp = ST_HOLD;
			`QMRP_OP_QEN: decodeOp = q ? ST_SKIP : ST_HOLD;
			`QMRP_OP_QDIS: decodeOp = q ? ST_HOLD : ST_SKIP;
			`QMRP_OP_FREAD, `QMRP_OP_SFDP: decodeOp = ST_ADDR;
			`QMRP_OP_WRAPRD, `QMRP_OP_QIOR: decodeOp = q ? ST_ADDR : ST_SKIP;
			`QMRP_OP_SETRP: decodeOp = q ? ST_DIN : ST_SKIP;
			`QMRP_OP_SBW: decodeOp = q ? ST_SKIP : ST_DIN;
			default: decodeOp = ST_SKIP;
		endcase
	endfunction : decodeOp

	// dummy clocks per command; quad reads follow the read parameters
	function automatic logic [3:0] dummyFor(input logic [7:0] op, input logic q,
		input logic [7:0] rp);
		if (op == `QMRP_OP_SFDP || !q) begin
			dummyFor = (op == `QMRP_OP_SFDP) ? `QMRP_DUM_SFDP : `QMRP_DUM_STD;
		end else begin
			case (rp[5:4])
				2'h2: dummyFor = `QMRP_DUM_6;
				2'h3: dummyFor = `QMRP_DUM_8;
				default: dummyFor = `QMRP_DUM_4;
			endcase
		end
	endfunction : dummyFor

	logic sclkRise, sclkFall, csRise, csFall, busy, byteDone, wrapOn;
	logic [2:0] step, bitNew;
	logic [7:0] shNew, outByte;
	logic [23:0] wrapMask, addrInc;

	assign sclkRise = sclk & ~sclkD_r;
	assign sclkFall = ~sclk & sclkD_r;
	assign csRise = csN & ~csD_r;
	assign csFall = ~csN & csD_r;
	assign busy = (busy_r != '0);
	assign step = quad_r ? `QMRP_STEP_QUAD : `QMRP_STEP_STD;
	assign shNew = quad_r ? {sh_r[3:0], ioIn} : {sh_r[6:0], ioIn[0]};
	assign bitNew = bitCnt_r + step;
	assign byteDone = (bitNew == 3'h0);
	assign outByte = (opc_r == `QMRP_OP_SFDP) ? romData : memData;
	// window mask from the one shared wrap length
	assign wrapMask = (`QMRP_WRAP_BASE << wrapLen_r) - 24'h000001;
	assign wrapOn = quad_r && (opc_r == `QMRP_OP_WRAPRD);
	assign addrInc = addr_r + 24'h000001;

	// status word seen over apb
	always_comb begin
		statWord = '0;
		statWord[`QMRP_ST_QUAD] = quad_r;
		statWord[`QMRP_ST_WEL] = wel_r;
		statWord[`QMRP_ST_SUS] = sus_r;
		statWord[`QMRP_ST_BUSY] = busy;
		statWord[`QMRP_ST_ARM] = arm_r;
		statWord[`QMRP_ST_RP +: 8] = rp_r;
		statWord[`QMRP_ST_WRAP +: 3] = wrapBits_r;
		statWord[`QMRP_ST_WLEN +: 2] = wrapLen_r;
		statWord[`QMRP_ST_MODE +: 8] = modeBits_r;
	end

	// ==============================================================
	// next-state logic for apb and serial engine
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		opc_nxt = opc_r;
		sh_nxt = sh_r;
		outSh_nxt = outSh_r;
		rp_nxt = rp_r;
		modeBits_nxt = modeBits_r;
		bitCnt_nxt = bitCnt_r;
		outCnt_nxt = outCnt_r;
		wrapBits_nxt = wrapBits_r;
		byteCnt_nxt = byteCnt_r;
		wrapLen_nxt = wrapLen_r;
		cnt_nxt = cnt_r;
		quad_nxt = quad_r;
		wel_nxt = wel_r;
		sus_nxt = sus_r;
		qe_nxt = qe_r;
		arm_nxt = arm_r;
		busy_nxt = busy ? busy_r - BW'(1) : busy_r;
		prdata_nxt = prdata_r;

		// apb: read data latched in setup, write lands in access
		if (psel && !penable) begin
			case (paddr)
				`QMRP_REG_CTRL: begin
					prdata_nxt = '0;
					prdata_nxt[`QMRP_CTRL_QE] = qe_r;
					prdata_nxt[`QMRP_CTRL_SUS] = sus_r;
				end
				`QMRP_REG_STAT: prdata_nxt = statWord;
				default: prdata_nxt = '0;
			endcase
		end
		if (psel && penable && pwrite && paddr == `QMRP_REG_CTRL) begin
			qe_nxt = pwdata[`QMRP_CTRL_QE];
			sus_nxt = pwdata[`QMRP_CTRL_SUS];
		end

		if (csRise) begin
			// frame end: single-byte commands act only on a clean 8-bit frame
			state_nxt = ST_IDLE;
			arm_nxt = (state_r == ST_HOLD) && (opc_r == `QMRP_OP_RSTEN);
			if (state_r == ST_HOLD) begin
				case (opc_r)
					`QMRP_OP_WREN: wel_nxt = 1'b1;
					`QMRP_OP_WRDI: wel_nxt = 1'b0;
					`QMRP_OP_QEN: quad_nxt = qe_r;
					`QMRP_OP_QDIS: quad_nxt = 1'b0;
					`QMRP_OP_RST: begin
						if (arm_r) begin
							wel_nxt = 1'b0;
							sus_nxt = 1'b0;
							rp_nxt = '0;
							modeBits_nxt = '0;
							wrapBits_nxt = '0;
							wrapLen_nxt = '0;
							quad_nxt = 1'b0;
							busy_nxt = RST_LOAD;
						end
					end
					default: ;
				endcase
			end
		end else if (csFall) begin
			// a frame opened during recovery is dropped whole
			state_nxt = busy ? ST_SKIP : ST_OPC;
			bitCnt_nxt = '0;
			byteCnt_nxt = '0;
			cnt_nxt = '0;
			outCnt_nxt = '0;
			outSh_nxt = '0;
		end else if (sclkRise) begin
			case (state_r)
				ST_OPC: begin
					sh_nxt = shNew;
					bitCnt_nxt = bitNew;
					if (byteDone) begin
						opc_nxt = shNew;
						state_nxt = decodeOp(shNew, quad_r);
					end
				end
				ST_ADDR: begin
					sh_nxt = shNew;
					bitCnt_nxt = bitNew;
					if (byteDone) begin
						addr_nxt = {addr_r[15:0], shNew};
						byteCnt_nxt = byteCnt_r + 2'h1;
						if (byteCnt_r == `QMRP_ADDR_BYTES) begin
							byteCnt_nxt = '0;
							state_nxt = (opc_r == `QMRP_OP_QIOR) ? ST_MODE : ST_DUMMY;
						end
					end
				end
				ST_MODE: begin
					sh_nxt = shNew;
					bitCnt_nxt = bitNew;
					if (byteDone) begin
						modeBits_nxt = shNew;
						state_nxt = ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r + 4'h1 == dummyFor(opc_r, quad_r, rp_r)) begin
						state_nxt = ST_DOUT;
					end
				end
				ST_DIN: begin
					sh_nxt = shNew;
					bitCnt_nxt = bitNew;
					if (byteDone) begin
						if (opc_r == `QMRP_OP_SETRP) begin
							rp_nxt = shNew;
							wrapLen_nxt = shNew[1:0];
							state_nxt = ST_SKIP;
						end else begin
							byteCnt_nxt = byteCnt_r + 2'h1;
							if (byteCnt_r == `QMRP_SBW_BYTES) begin
								wrapBits_nxt = shNew[6:4];
								wrapLen_nxt = shNew[6:5];
								state_nxt = ST_SKIP;
							end
						end
					end
				end
				// extra clocks after a single-byte opcode void it
				ST_HOLD: state_nxt = ST_SKIP;
				default: ;
			endcase
		end else if (sclkFall && state_r == ST_DOUT) begin
			// load a byte on each byte boundary, else shift
			outCnt_nxt = outCnt_r + step;
			if (outCnt_r == 3'h0) begin
				outSh_nxt = outByte;
				addr_nxt = wrapOn ? ((addr_r & ~wrapMask) | (addrInc & wrapMask))
					: addrInc;
			end else begin
				outSh_nxt = quad_r ? {outSh_r[3:0], 4'h0} : {outSh_r[6:0], 1'b0};
			end
		end
	end

	// ==============================================================
	// registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			addr_r <= '0;
			opc_r <= '0;
			sh_r <= '0;
			outSh_r <= '0;
			rp_r <= '0;
			modeBits_r <= '0;
			bitCnt_r <= '0;
			outCnt_r <= '0;
			wrapBits_r <= '0;
			byteCnt_r <= '0;
			wrapLen_r <= '0;
			cnt_r <= '0;
			quad_r <= 1'b0;
			wel_r <= 1'b0;
			sus_r <= 1'b0;
			qe_r <= 1'b0;
			arm_r <= 1'b0;
			busy_r <= '0;
			prdata_r <= '0;
			sclkD_r <= 1'b0;
			csD_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			opc_r <= opc_nxt;
			sh_r <= sh_nxt;
			outSh_r <= outSh_nxt;
			rp_r <= rp_nxt;
			modeBits_r <= modeBits_nxt;
			bitCnt_r <= bitCnt_nxt;
			outCnt_r <= outCnt_nxt;
			wrapBits_r <= wrapBits_nxt;
			byteCnt_r <= byteCnt_nxt;
			wrapLen_r <= wrapLen_nxt;
			cnt_r <= cnt_nxt;
			quad_r <= quad_nxt;
			wel_r <= wel_nxt;
			sus_r <= sus_nxt;
			qe_r <= qe_nxt;
			arm_r <= arm_nxt;
			busy_r <= busy_nxt;
			prdata_r <= prdata_nxt;
			sclkD_r <= sclk;
			csD_r <= csN;
		end
	end

	// ==============================================================
	// outputs; standard mode answers on io[1] only
	assign pinDrive.ioOut = quad_r ? outSh_r[7:4] : {2'b00, outSh_r[7], 1'b0};
	assign pinDrive.ioOeN = (state_r != ST_DOUT) ? `QMRP_OEN_OFF
		: (quad_r ? `QMRP_OEN_ALL : `QMRP_OEN_SO);
	assign memAddr = addr_r;
	assign quadMode = quad_r;
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && paddr != `QMRP_REG_CTRL && paddr != `QMRP_REG_STAT;
endmodule : qmrp_cmd_engine

// >>> tb/qmrp_engine_monitor.sv
`include "qmrp_defs.svh"

// ==============================================================
// port checker
module qmrp_engine_monitor
	import qmrp_pkg::*;
#(
	parameter int AW = 12
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire qmrp_pins_s pinIn,
	input wire qmrp_drive_s pinDrive,
	input wire logic quadMode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// mode moves only at a frame end, seen through the pin sync delay
	property p_qen_frame;
		$rose(quadMode) |-> pinIn.csN;
	endproperty
	a_qen_frame: assert property (p_qen_frame) else $error("mode entered in frame");
	property p_qdis_frame;
		$fell(quadMode) |-> pinIn.csN;
	endproperty
	a_qdis_frame: assert property (p_qdis_frame) else $error("mode left in frame");
	property p_mode_steady;
		!pinIn.csN [*8] |-> $stable(quadMode);
	endproperty
	a_mode_steady: assert property (p_mode_steady) else $error("mode moved mid frame");
	// quad output uses all lines, standard output only the second one
	property p_quad_lines;
		quadMode && pinDrive.ioOeN != 4'hF |-> pinDrive.ioOeN == 4'h0;
	endproperty
	a_quad_lines: assert property (p_quad_lines) else $error("quad drive width");
	property p_std_line;
		!quadMode && pinDrive.ioOeN != 4'hF |-> pinDrive.ioOeN == 4'hD;
	endproperty
	a_std_line: assert property (p_std_line) else $error("standard drive width");
	property p_release;
		pinIn.csN [*8] |-> pinDrive.ioOeN == 4'hF;
	endproperty
	a_release: assert property (p_release) else $error("lines held after frame");
	// output only shifts on a clock fall, so a long high phase keeps it
	property p_out_steady;
		pinIn.sclk [*8] |-> $stable(pinDrive.ioOut);
	endproperty
	a_out_steady: assert property (p_out_steady) else $error("output moved on high");
	property p_stat_mode;
		psel && penable && paddr == AW'(`QMRP_REG_STAT) |-> prdata[0] == $past(quadMode);
	endproperty
	a_stat_mode: assert property (p_stat_mode) else $error("status mode bit wrong");
endmodule : qmrp_engine_monitor

bind qmrp_cmd_engine qmrp_engine_monitor #(.AW(AW)) u_mon (.clock(clock), .resetn(resetn),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pinIn(pinIn),
	.pinDrive(pinDrive), .quadMode(quadMode));

// >>> tb/qmrp_host_model.sv
// ==============================================================
// serial host: clock stands low between frames
module qmrp_host_model
	import qmrp_pkg::*;
#(
	parameter int HALF = 20
) (
	input wire logic clock,
	input wire qmrp_drive_s drv,
	output qmrp_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic csN = 1'b1;
	logic sclk = 1'b0;
	logic [3:0] hio = 4'h0;
	logic [3:0] io;
	// device wins the lines it enables
	assign io = (drv.ioOeN & hio) | (~drv.ioOeN & drv.ioOut);
	assign pins = {csN, sclk, io};

	task half;
		repeat (HALF) @(posedge clock);
	endtask : half
	task tick;
		half();
		sclk <= 1'b1;
		half();
		sclk <= 1'b0;
	endtask : tick

	task automatic frame(input logic q, input logic [7:0] tx[$], input int dum, input int nRx,
		output logic [7:0] rx[$]);
		int s;
		logic [7:0] b;
		s = q ? 4 : 1;
		rx = {};
		csN <= 1'b0;
		half();
		foreach (tx[i]) begin
			for (int k = 8 - s; k >= 0; k -= s) begin
				hio <= q ? 4'(tx[i] >> k) : {3'h0, tx[i][k]};
				tick();
			end
		end
		// dummies: lines keep toggling so stale values are never read
		repeat (dum) begin
			hio <= ~hio;
			tick();
		end
		repeat (nRx) begin
			b = 8'h00;
			for (int k = 0; k < 8; k += s) begin
				hio <= ~hio;
				half();
				b = q ? {b[3:0], io} : {b[6:0], io[1]};
				sclk <= 1'b1;
				half();
				sclk <= 1'b0;
			end
			rx.push_back(b);
		end
		half();
		csN <= 1'b1;
		half();
	endtask : frame
endmodule : qmrp_host_model

// >>> tb/tb.sv
`include "qmrp_defs.svh"

module tb;
	import qmrp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MAKER = 8'h5E; // arbitrary value
	localparam int DUM[4] = '{4, 4, 6, 8};
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	qmrp_pins_s pinIn;
	qmrp_drive_s pinDrive;
	logic [23:0] memAddr;
	logic [7:0] memData = 8'h00;
	logic quadMode;
	logic [31:0] rd;
	logic er;
	logic [7:0] rx[$];
	int error_cnt = 0;
	int n_tests = 0;
	logic [7:0] sfdpExp[24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
		MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};

	initial forever #2 clock = ~clock;
	// array stand-in, answers one clock after the address moves
	always @(posedge clock) memData <= memAddr[7:0] ^ 8'hA5;

	qmrp_cmd_engine #(.RST_NS(800), .MAKER_ID(MAKER)) uut (.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
		.pinDrive(pinDrive), .memAddr(memAddr), .memData(memData), .quadMode(quadMode));
	qmrp_host_model host (.clock(clock), .drv(pinDrive), .pins(pinIn));

	// ==============================================================
	// checks and bus tasks
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) begin
			error_cnt++;
			close_out();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clock);
		end
	endtask : apb
	// window base 0x100 is aligned for every wrap length
	task automatic wrapChk(input int win, input int dum, input int off);
		logic [23:0] a;
		a = 24'h000100 + 24'(off);
		host.frame(1'b1, {`QMRP_OP_WRAPRD, a[23:16], a[15:8], a[7:0]}, dum, 4, rx);
		for (int j = 0; j < 4; j++)
			chk("wrap byte", 32'(8'((off + j) % win) ^ 8'hA5), 32'(rx[j]));
	endtask : wrapChk
	// poll status until recovery ends; a hang counts as a mismatch
	task automatic waitIdle;
		int k;
		k = 0;
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		while (rd[3] !== 1'b0 && k < 500) begin
			apb(1'b0, `QMRP_REG_STAT, 32'h0);
			k++;
		end
		if (rd[3] !== 1'b0) begin
			error_cnt++;
			close_out();
		end
	endtask : waitIdle

	// ==============================================================
	// main sequence
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		repeat (8) @(posedge clock);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped err", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rd);
		host.frame(1'b0, {`QMRP_OP_QEN}, 0, 0, rx);
		chk("mode qe0", 32'h0, 32'(quadMode));
		apb(1'b1, `QMRP_REG_CTRL, 32'h1);
		host.frame(1'b0, {`QMRP_OP_WREN}, 0, 0, rx);
		host.frame(1'b0, {`QMRP_OP_SBW, 8'hFF, 8'hFF, 8'hFF, 8'h20}, 0, 0, rx);
		host.frame(1'b0, {`QMRP_OP_QEN}, 0, 0, rx);
		chk("mode on", 32'h1, 32'(quadMode));
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("stat entry", 32'h00120003, rd);
		$display("test mode entry done");
		wrapChk(16, 4, 14);
		for (int i = 0; i < 4; i++) begin
			host.frame(1'b1, {`QMRP_OP_SETRP, 8'(i * 17)}, 0, 0, rx);
			wrapChk(8 << i, DUM[i], (8 << i) - 2);
			apb(1'b0, `QMRP_REG_STAT, 32'h0);
			chk("param bits", 32'(i * 17), 32'(rd[15:8]));
			chk("wrap code", 32'(i), 32'(rd[21:20]));
		end
		// plain fast read must not wrap at the 64-byte edge
		host.frame(1'b1, {`QMRP_OP_FREAD, 8'h00, 8'h01, 8'h3F}, 8, 2, rx);
		chk("fast byte 0", 32'h9A, 32'(rx[0]));
		chk("fast byte 1", 32'hE5, 32'(rx[1]));
		// quad i/o read: mode byte, then read-parameter dummies
		host.frame(1'b1, {`QMRP_OP_QIOR, 8'h00, 8'h01, 8'h20, 8'h5C}, 8, 2, rx);
		chk("qio byte 0", 32'h85, 32'(rx[0]));
		chk("qio byte 1", 32'h84, 32'(rx[1]));
		$display("test wrapped reads done");
		host.frame(1'b1, {`QMRP_OP_QDIS}, 0, 0, rx);
		chk("mode off", 32'h0, 32'(quadMode));
		// read parameters are refused outside quad mode
		host.frame(1'b0, {`QMRP_OP_SETRP, 8'h00}, 0, 0, rx);
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("stat exit", 32'h5C323302, rd);
		host.frame(1'b0, {`QMRP_OP_SFDP, 8'h00, 8'h00, 8'h00}, 8, 24, rx);
		foreach (sfdpExp[i])
			chk("table byte", 32'(sfdpExp[i]), 32'(rx[i]));
		$display("test table done");
		// a lone reset opcode must do nothing
		host.frame(1'b0, {`QMRP_OP_RST}, 0, 0, rx);
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("lone reset", 32'h1, 32'(rd[1]));
		host.frame(1'b0, {`QMRP_OP_WRDI}, 0, 0, rx);
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("latch clear", 32'h0, 32'(rd[1]));
		host.frame(1'b0, {`QMRP_OP_WREN}, 0, 0, rx);
		apb(1'b1, `QMRP_REG_CTRL, 32'h3);
		host.frame(1'b0, {`QMRP_OP_QEN}, 0, 0, rx);
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("suspend seen", 32'h1, 32'(rd[2]));
		host.frame(1'b1, {`QMRP_OP_RSTEN}, 0, 0, rx);
		host.frame(1'b1, {`QMRP_OP_RST}, 0, 0, rx);
		apb(1'b0, `QMRP_REG_STAT, 32'h0);
		chk("recovery busy", 32'h1, 32'(rd[3]));
		host.frame(1'b0, {`QMRP_OP_WREN}, 0, 0, rx);
		waitIdle();
		chk("stat reset", 32'h0, rd);
		apb(1'b0, `QMRP_REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		// same pair in standard mode; latch set first so the clear shows
		host.frame(1'b0, {`QMRP_OP_WREN}, 0, 0, rx);
		host.frame(1'b0, {`QMRP_OP_RSTEN}, 0, 0, rx);
		host.frame(1'b0, {`QMRP_OP_RST}, 0, 0, rx);
		waitIdle();
		chk("std reset latch", 32'h0, 32'(rd[1]));
		$display("test reset done");
		close_out();
	end
endmodule : tb
